// [mlsc_dev_end.sv]
// Purpose: Module-side low-speed control: select, reset, interrupt, power cap
// Assumes: Pins sampled synchronously; host drives the serial clock slowly
// Notes: Small management map behind a 2-wire slave with pointer write
`timescale 1ns/1ps
`include "mlsc_regs.svh"
module mlsc_dev_end #(
    parameter int unsigned RST_FILT_CYCLES = `MLSC_RST_FILT_DEF,
    parameter logic [6:0] DEV_ADDR = `MLSC_DEV_ADDR_DEF
) (
    input wire logic sys_clk_i, // System clock
    input wire logic rst_n_i,   // Power-on reset, low
    mlsc_if.dev lnk,            // Pins toward host
    input wire logic fault_i,   // Internal fault event
    output logic power_cap_o,   // Power limit in force
    output logic ready_o,       // Status valid
    output logic in_reset_o     // Filtered reset held
);
    import mlsc_pkg::*;

    localparam mlsc_cnt_t INIT_CYC = mlsc_cnt_t'(`MLSC_INIT_NS / `MLSC_CLK_NS);
    localparam mlsc_dev_s DEV_RST = '{
        st: S_IDLE, cnt: '0, sh: '0, ptr: '0, rw: 1'h0, addr_ph: 1'h0, ptr_ph: 1'h0,
        scl_p: 1'h1, sda_p: 1'h1, sda_oe: 1'h0, int_oe: 1'h0, prs_oe: 1'h1, dnr: 1'h1,
        flags: '0, mask: '0, ctrl_lp: 1'h0, power_cap: 1'h0, in_reset: 1'h0,
        init_busy: 1'h1, init_cnt: '0
    };

    mlsc_dev_s q;
    mlsc_dev_s d;
    logic hold;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    mlsc_byte_t rd_data;

    // Filtered reset pin
    mlsc_rst_filt #(
        .FILT_CYCLES(RST_FILT_CYCLES)
    ) u_filt (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .reset_in_n_i(lnk.module_reset_n),
        .hold_o(hold)
    );

    // Bus line events
    assign scl_rise = lnk.scl && !q.scl_p;
    assign scl_fall = !lnk.scl && q.scl_p;
    assign start_c = lnk.scl && q.scl_p && q.sda_p && !lnk.sda;
    assign stop_c = lnk.scl && q.scl_p && !q.sda_p && lnk.sda;

    // Read side of the management map
    always_comb begin
        rd_data = '0;
        case (q.ptr)
            `MLSC_OFS_STATUS: rd_data[`MLSC_BIT_DNR] = q.dnr;
            `MLSC_OFS_FLAGS: rd_data[`MLSC_FLG_W-1:0] = q.flags;
            `MLSC_OFS_MASK: rd_data[`MLSC_FLG_W-1:0] = q.mask;
            `MLSC_OFS_CTRL: rd_data[`MLSC_CTL_LP] = q.ctrl_lp;
            default: rd_data = '0;
        endcase
    end

    // Next state of slave, map and reset sequencing
    always_comb begin
        logic wr_en;
        logic rd_en;
        mlsc_flg_t set;
        mlsc_flg_t clr;
        wr_en = 1'h0;
        rd_en = 1'h0;
        set = '0;
        clr = '0;
        d = q;
        d.scl_p = lnk.scl;
        d.sda_p = lnk.sda;
        if (lnk.module_select_n || stop_c) begin
            d.st = S_IDLE;
            d.sda_oe = 1'h0;
        end else if (start_c) begin
            d.st = S_RX;
            d.cnt = '0;
            d.addr_ph = 1'h1;
            d.sda_oe = 1'h0;
        end else begin
            case (q.st)
                S_RX: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[6:0], lnk.sda};
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == `MLSC_LAST_BIT) begin
                            d.st = S_ACKW;
                        end
                    end
                end
                S_ACKW: begin
                    if (scl_fall) begin
                        if (q.addr_ph) begin
                            if (q.sh[7:1] == DEV_ADDR) begin
                                d.sda_oe = 1'h1;
                                d.rw = q.sh[0];
                                d.addr_ph = 1'h0;
                                d.ptr_ph = !q.sh[0];
                                d.st = S_ACKH;
                            end else begin
                                d.st = S_IDLE;
                            end
                        end else begin
                            d.sda_oe = 1'h1;
                            d.st = S_ACKH;
                            if (q.ptr_ph) begin
                                d.ptr = q.sh;
                                d.ptr_ph = 1'h0;
                            end else begin
                                wr_en = 1'h1;
                                d.ptr = q.ptr + 8'h01;
                            end
                        end
                    end
                end
                S_ACKH: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'h0;
                        d.cnt = '0;
                        if (q.rw) begin
                            d.sh = rd_data;
                            d.sda_oe = !rd_data[7];
                            d.ptr = q.ptr + 8'h01;
                            rd_en = 1'h1;
                            d.st = S_TX;
                        end else begin
                            d.st = S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        if (q.cnt == `MLSC_LAST_BIT) begin
                            d.sda_oe = 1'h0;
                            d.st = S_TXACK;
                        end else begin
                            d.sda_oe = !q.sh[6];
                            d.sh = {q.sh[6:0], 1'h0};
                            d.cnt = q.cnt + 3'h1;
                        end
                    end
                end
                S_TXACK: begin
                    if (scl_rise) begin
                        d.st = lnk.sda ? S_IDLE : S_ACKH;
                    end
                end
                default: d.st = S_IDLE;
            endcase
        end

        // Writable map fields
        if (wr_en) begin
            case (q.ptr)
                `MLSC_OFS_MASK: d.mask = q.sh[`MLSC_FLG_W-1:0];
                `MLSC_OFS_CTRL: d.ctrl_lp = q.sh[`MLSC_CTL_LP];
                default: d.ctrl_lp = q.ctrl_lp;
            endcase
        end
        // Flags clear when read
        if (rd_en && q.ptr == `MLSC_OFS_FLAGS) begin
            clr = '1;
        end

        if (q.init_busy) begin
            if (q.init_cnt == INIT_CYC - mlsc_cnt_t'(1)) begin
                d.init_busy = 1'h0;
                d.dnr = 1'h0;
                set[`MLSC_FLG_RST] = 1'h1;
            end else begin
                d.init_cnt = q.init_cnt + mlsc_cnt_t'(1);
            end
        end
        set[`MLSC_FLG_FLT] = fault_i;
        d.flags = (q.flags & ~clr) | set;

        d.int_oe = |(d.flags & ~d.mask);
        d.power_cap = lnk.low_power_request || d.ctrl_lp;
        d.prs_oe = 1'h1;
        d.in_reset = 1'h0;

        if (hold) begin
            d = DEV_RST;
            d.scl_p = lnk.scl;
            d.sda_p = lnk.sda;
            d.in_reset = 1'h1;
            d.power_cap = lnk.low_power_request;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // Pin and user outputs
    assign lnk.dev_sda_o = 1'h0;
    assign lnk.dev_sda_oe = q.sda_oe;
    assign lnk.dev_int_o = 1'h0;
    assign lnk.dev_int_oe = q.int_oe;
    assign lnk.dev_prs_o = 1'h0;
    assign lnk.dev_prs_oe = q.prs_oe;
    assign power_cap_o = q.power_cap;
    assign ready_o = !q.dnr;
    assign in_reset_o = q.in_reset;
endmodule

// [mlsc_regs.svh]
// Purpose: Named constants of the module low-speed control pair
// Assumes: 250 MHz system clock on both ends
// Notes: Offsets address the small management map behind the 2-wire bus
`ifndef MLSC_REGS_SVH
`define MLSC_REGS_SVH

// Clock and timing
`define MLSC_CLK_NS 4
`define MLSC_INIT_NS 1000
`define MLSC_CNT_W 16
`define MLSC_RST_FILT_DEF 16
`define MLSC_RST_PULSE_DEF 32
`define MLSC_SCL_DIV_DEF 8

// Bus address and map offsets
`define MLSC_DEV_ADDR_DEF 7'h50
`define MLSC_OFS_STATUS 8'h02
`define MLSC_OFS_FLAGS 8'h03
`define MLSC_OFS_MASK 8'h04
`define MLSC_OFS_CTRL 8'h05

// Field positions
`define MLSC_BIT_DNR 0
`define MLSC_FLG_W 2
`define MLSC_FLG_RST 0
`define MLSC_FLG_FLT 1
`define MLSC_CTL_LP 0

// Bit counts
`define MLSC_LAST_BIT 3'h7
`define MLSC_ACK_IDX 4'h8

`endif

// [mlsc_pkg.sv]
// Purpose: Types shared by both ends of the low-speed control link
// Assumes: Constants come from mlsc_regs.svh
// Notes: Each design module keeps all its state in one struct
`include "mlsc_regs.svh"
package mlsc_pkg;
    typedef logic [7:0] mlsc_byte_t;
    typedef logic [`MLSC_CNT_W-1:0] mlsc_cnt_t;
    typedef logic [`MLSC_FLG_W-1:0] mlsc_flg_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_RX = 3'h1, S_ACKW = 3'h2, S_ACKH = 3'h3, S_TX = 3'h4, S_TXACK = 3'h5
    } mlsc_slv_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_RST = 3'h1, H_START = 3'h2, H_BYTE = 3'h3, H_STOP = 3'h4
    } mlsc_hst_e;

    typedef enum logic [1:0] {PH_LOW = 2'h0, PH_HIGH = 2'h1, PH_SAMP = 2'h2} mlsc_ph_e;

    typedef enum logic [2:0] {
        ST_ADDR_W = 3'h0, ST_REG = 3'h1, ST_DATA = 3'h2, ST_ADDR_R = 3'h3, ST_RDATA = 3'h4
    } mlsc_stp_e;

    typedef struct packed {
        mlsc_cnt_t cnt;
        logic hold;
    } mlsc_filt_s;

    typedef struct packed {
        mlsc_slv_e st;
        logic [2:0] cnt;
        mlsc_byte_t sh;
        mlsc_byte_t ptr;
        logic rw;
        logic addr_ph;
        logic ptr_ph;
        logic scl_p;
        logic sda_p;
        logic sda_oe;
        logic int_oe;
        logic prs_oe;
        logic dnr;
        mlsc_flg_t flags;
        mlsc_flg_t mask;
        logic ctrl_lp;
        logic power_cap;
        logic in_reset;
        logic init_busy;
        mlsc_cnt_t init_cnt;
    } mlsc_dev_s;

    typedef struct packed {
        mlsc_hst_e st;
        mlsc_ph_e ph;
        logic [3:0] bi;
        mlsc_stp_e stp;
        mlsc_byte_t sh;
        logic [8:0] rx;
        mlsc_cnt_t div;
        mlsc_cnt_t rc;
        logic wr;
        logic auto_rd;
        mlsc_byte_t addr;
        mlsc_byte_t data;
        logic scl;
        logic sda_oe;
        logic sel_n;
        logic rst_n;
        logic lp;
        logic err;
        logic rdy;
        logic rsp_v;
        mlsc_byte_t rsp_d;
        logic rsp_irq;
        logic present;
        logic stat_v;
    } mlsc_host_s;
endpackage

// [mlsc_if.sv]
// Purpose: Pins between host controller and pluggable module
// Assumes: Pull-ups on data, interrupt and present lines
// Notes: Open-drain levels are resolved here from the enables
`timescale 1ns/1ps
interface mlsc_if;
    logic scl;
    logic module_select_n;
    logic module_reset_n;
    logic low_power_request;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic dev_int_o;
    logic dev_int_oe;
    logic dev_prs_o;
    logic dev_prs_oe;
    logic sda;
    logic interrupt_n;
    logic module_present_n;

    // Wired-AND with pull-up on each shared line
    assign sda = ((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o)) ? 1'h0 : 1'h1;
    assign interrupt_n = (dev_int_oe && !dev_int_o) ? 1'h0 : 1'h1;
    assign module_present_n = (dev_prs_oe && !dev_prs_o) ? 1'h0 : 1'h1;

    modport dev (
        input scl, module_select_n, module_reset_n, low_power_request, sda,
        output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe, dev_prs_o, dev_prs_oe
    );
    modport host (
        output scl, module_select_n, module_reset_n, low_power_request,
        output host_sda_o, host_sda_oe,
        input sda, interrupt_n, module_present_n
    );
endinterface

// [mlsc_rst_filt.sv]
// Purpose: Minimum-length filter on the module reset input
// Assumes: Reset input synchronous to sys_clk_i
// Notes: Hold rises after more than FILT_CYCLES low samples
`timescale 1ns/1ps
`include "mlsc_regs.svh"
module mlsc_rst_filt #(
    parameter int unsigned FILT_CYCLES = `MLSC_RST_FILT_DEF
) (
    input wire logic sys_clk_i,    // System clock
    input wire logic rst_n_i,      // Async reset, low
    input wire logic reset_in_n_i, // Raw reset pin, low
    output logic hold_o            // Filtered reset active
);
    import mlsc_pkg::*;

    localparam mlsc_cnt_t FILT = mlsc_cnt_t'(FILT_CYCLES);
    mlsc_filt_s q;
    mlsc_filt_s d;

    // Count low samples; short pulses restart the count
    always_comb begin
        d = q;
        if (reset_in_n_i) begin
            d.cnt = '0;
            d.hold = 1'h0;
        end else if (q.cnt == FILT) begin
            d.hold = 1'h1;
        end else begin
            d.cnt = q.cnt + mlsc_cnt_t'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign hold_o = q.hold;
endmodule

// [mlsc_host_end.sv]
// Purpose: Host-side controller: select, reset pulse, 2-wire master
// Assumes: One module per select line
// Notes: Interrupt triggers an automatic read of the flag register
`timescale 1ns/1ps
`include "mlsc_regs.svh"
module mlsc_host_end #(
    parameter int unsigned SCL_DIV = `MLSC_SCL_DIV_DEF,
    parameter int unsigned RST_PULSE = `MLSC_RST_PULSE_DEF,
    parameter logic [6:0] DEV_ADDR = `MLSC_DEV_ADDR_DEF
) (
    input wire logic sys_clk_i,                // System clock
    input wire logic rst_n_i,                  // Async reset, low
    mlsc_if.host lnk,                          // Pins toward module
    input wire logic cmd_valid_i,              // Command offered
    input wire logic cmd_write_i,              // Command is write
    input wire mlsc_pkg::mlsc_byte_t cmd_addr_i,  // Map offset
    input wire mlsc_pkg::mlsc_byte_t cmd_wdata_i, // Write byte
    output logic cmd_ready_o,                  // Command taken
    output logic rsp_valid_o,                  // Answer pulse
    output mlsc_pkg::mlsc_byte_t rsp_data_o,   // Read byte
    output logic rsp_err_o,                    // Missing acknowledge
    output logic rsp_irq_o,                    // Answer of interrupt read
    input wire logic reset_req_i,              // Reset module pulse
    input wire logic low_power_i,              // Low-power request
    output logic present_o,                    // Module inserted
    output logic status_valid_o                // Status may be trusted
);
    import mlsc_pkg::*;

    localparam mlsc_cnt_t DIV_LAST = mlsc_cnt_t'(SCL_DIV - 1);
    localparam mlsc_cnt_t RST_LAST = mlsc_cnt_t'(RST_PULSE - 1);

    mlsc_host_s q;
    mlsc_host_s d;
    logic tick;

    // Byte sent in each step; all ones releases data for reading
    function automatic mlsc_byte_t step_byte(input mlsc_stp_e s, input mlsc_byte_t a,
                                             input mlsc_byte_t w);
        case (s)
            ST_ADDR_W: step_byte = {DEV_ADDR, 1'h0};
            ST_REG: step_byte = a;
            ST_DATA: step_byte = w;
            ST_ADDR_R: step_byte = {DEV_ADDR, 1'h1};
            default: step_byte = 8'hFF;
        endcase
    endfunction

    assign tick = (q.div == DIV_LAST);

    // Sequencer
    always_comb begin
        d = q;
        d.rsp_v = 1'h0;
        d.lp = low_power_i;
        d.present = !lnk.module_present_n;
        d.div = tick ? '0 : q.div + mlsc_cnt_t'(1);
        case (q.st)
            H_IDLE: begin
                d.rdy = lnk.interrupt_n && !reset_req_i;
                if (cmd_valid_i && q.rdy) begin
                    d.wr = cmd_write_i;
                    d.addr = cmd_addr_i;
                    d.data = cmd_wdata_i;
                    d.auto_rd = 1'h0;
                end else if (reset_req_i) begin
                    d.st = H_RST;
                    d.rc = '0;
                    d.rst_n = 1'h0;
                    d.stat_v = 1'h0;
                end else if (!lnk.interrupt_n) begin
                    d.wr = 1'h0;
                    d.addr = `MLSC_OFS_FLAGS;
                    d.auto_rd = 1'h1;
                end
                if ((cmd_valid_i && q.rdy) || (!reset_req_i && !lnk.interrupt_n)) begin
                    d.sel_n = 1'h0;
                    d.rdy = 1'h0;
                    d.err = 1'h0;
                    d.st = H_START;
                    d.ph = PH_LOW;
                    d.stp = ST_ADDR_W;
                end
            end
            H_RST: begin
                d.rc = q.rc + mlsc_cnt_t'(1);
                if (q.rc == RST_LAST) begin
                    d.rst_n = 1'h1;
                    d.st = H_IDLE;
                end
            end
            default: begin
                if (tick) begin
                    case (q.ph)
                        PH_LOW: begin
                            d.scl = 1'h0;
                            d.ph = PH_HIGH;
                            if (q.st == H_BYTE) begin
                                d.sda_oe = (q.bi != `MLSC_ACK_IDX) && !q.sh[7];
                            end else begin
                                d.sda_oe = (q.st == H_STOP);
                            end
                        end
                        PH_HIGH: begin
                            d.scl = 1'h1;
                            d.ph = PH_SAMP;
                        end
                        default: begin
                            d.ph = PH_LOW;
                            if (q.st == H_START) begin
                                d.sda_oe = 1'h1;
                                d.st = H_BYTE;
                                d.bi = '0;
                                d.sh = step_byte(q.stp, q.addr, q.data);
                            end else if (q.st == H_STOP) begin
                                d.sda_oe = 1'h0;
                                d.sel_n = 1'h1;
                                d.st = H_IDLE;
                                d.rsp_v = 1'h1;
                                d.rsp_d = q.wr ? 8'h00 : q.rx[8:1];
                                d.rsp_irq = q.auto_rd;
                                if (q.auto_rd && !q.err && q.rx[1 + `MLSC_FLG_RST]) begin
                                    d.stat_v = 1'h1;
                                end
                            end else begin
                                d.rx = {q.rx[7:0], lnk.sda};
                                d.sh = {q.sh[6:0], 1'h1};
                                d.bi = q.bi + 4'h1;
                                if (q.bi == `MLSC_ACK_IDX) begin
                                    if (lnk.sda && q.stp != ST_RDATA) begin
                                        d.err = 1'h1;
                                        d.st = H_STOP;
                                    end else begin
                                        case (q.stp)
                                            ST_ADDR_W: d.stp = ST_REG;
                                            ST_REG: d.stp = q.wr ? ST_DATA : ST_ADDR_R;
                                            ST_ADDR_R: d.stp = ST_RDATA;
                                            default: d.stp = q.stp;
                                        endcase
                                        if (q.stp == ST_REG && !q.wr) begin
                                            d.st = H_START;
                                        end else if (q.stp == ST_DATA || q.stp == ST_RDATA) begin
                                            d.st = H_STOP;
                                        end else begin
                                            d.bi = '0;
                                            d.sh = step_byte(d.stp, q.addr, q.data);
                                        end
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{st: H_IDLE, ph: PH_LOW, stp: ST_ADDR_W, scl: 1'h1, sel_n: 1'h1,
                   rst_n: 1'h1, default: '0};
        end else begin
            q <= d;
        end
    end

    // Pin and user outputs
    assign lnk.scl = q.scl;
    assign lnk.module_select_n = q.sel_n;
    assign lnk.module_reset_n = q.rst_n;
    assign lnk.low_power_request = q.lp;
    assign lnk.host_sda_o = 1'h0;
    assign lnk.host_sda_oe = q.sda_oe;
    assign cmd_ready_o = q.rdy;
    assign rsp_valid_o = q.rsp_v;
    assign rsp_data_o = q.rsp_d;
    assign rsp_err_o = q.err;
    assign rsp_irq_o = q.rsp_irq;
    assign present_o = q.present;
    assign status_valid_o = q.stat_v;
endmodule

// [mlsc_asserts.sv]
// Purpose: Pin checks across the host and module link
// Assumes: One clock; resolved wires seen
// Notes: Reset pin low count kept in helper logic
`timescale 1ns/1ps
module mlsc_asserts #(
    parameter int unsigned FILT = 4
) (
    input wire logic sys_clk_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire logic scl, // Bus clock
    input wire logic module_select_n, // Select
    input wire logic module_reset_n, // Reset pin
    input wire logic interrupt_n, // Irq wire
    input wire logic module_present_n, // Present
    input wire logic host_sda_oe, // Host pull
    input wire logic dev_sda_oe // Module pull
);
    logic [7:0] low_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Count reset pin low samples
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_q <= 8'h00;
        end else begin
            low_q <= module_reset_n ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
        end
    end
    chk_sel_gate: assert property (module_select_n [*3] |-> !dev_sda_oe)
        else $error("data pulled while deselected");
    chk_present_low: assert property (!module_present_n)
        else $error("present released");
    chk_no_early: assert property ($rose(rst_n_i) |-> interrupt_n [*8])
        else $error("interrupt too early");
    chk_powerup_int: assert property ($rose(rst_n_i) |-> ##[1:260] !interrupt_n)
        else $error("no power-up interrupt");
    chk_hold_quiet: assert property (low_q > FILT + 4 |-> interrupt_n)
        else $error("interrupt during reset");
    chk_reset_done: assert property ($rose(module_reset_n) && low_q > FILT + 4
        |-> ##[2:300] !interrupt_n)
        else $error("no reset-done interrupt");
    chk_scl_data: assert property (scl && $past(scl) && !module_select_n
        && !$past(module_select_n) |-> $stable(dev_sda_oe))
        else $error("data moved with clock high");
    chk_host_idle: assert property (module_select_n |-> scl && !host_sda_oe)
        else $error("bus active while deselected");
endmodule

// [mlsc_bench.sv]
// Purpose: Self-checking run of both ends
// Assumes: Small divider, pulse and filter
// Notes: Answers compared against queued notes
`timescale 1ns/1ps
module mlsc_bench;
    import mlsc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cv = 1'b0;
    logic cw = 1'b0;
    logic rq = 1'b0;
    logic lp = 1'b0;
    logic flt = 1'b0;
    logic seen = 1'b0;
    mlsc_byte_t ca = 8'h00;
    mlsc_byte_t cd = 8'h00;
    mlsc_byte_t rd;
    logic rdy, rv, re, ri, prs, sv, cap, rdy_d, inr;
    logic [8:0] exp_q[$];
    logic [31:0] rs = 32'hB4BD;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    mlsc_if lnk();
    mlsc_dev_end #(.RST_FILT_CYCLES(4)) mlsc_dev_end_i (.sys_clk_i, .rst_n_i, .lnk,
        .fault_i(flt), .power_cap_o(cap), .ready_o(rdy_d), .in_reset_o(inr));
    mlsc_host_end #(.SCL_DIV(2), .RST_PULSE(20)) mlsc_host_end_i (.sys_clk_i, .rst_n_i,
        .lnk, .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_addr_i(ca), .cmd_wdata_i(cd),
        .cmd_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rd), .rsp_err_o(re),
        .rsp_irq_o(ri), .reset_req_i(rq), .low_power_i(lp), .present_o(prs),
        .status_valid_o(sv));
    mlsc_asserts #(.FILT(4)) mlsc_asserts_i (.sys_clk_i, .rst_n_i, .scl(lnk.scl),
        .module_select_n(lnk.module_select_n), .module_reset_n(lnk.module_reset_n),
        .interrupt_n(lnk.interrupt_n), .module_present_n(lnk.module_present_n),
        .host_sda_oe(lnk.host_sda_oe), .dev_sda_oe(lnk.dev_sda_oe));
    initial forever #2 sys_clk_i = ~sys_clk_i;
    task automatic check(input string n, input logic [9:0] s, input logic [9:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Wait out all notes, then report
    task automatic settle(input string n);
        while (exp_q.size() != 0) @(posedge sys_clk_i);
        repeat (4) @(posedge sys_clk_i);
        $display("test %s done", n);
    endtask
    // One command held until taken
    task automatic cmd(input logic w, input mlsc_byte_t a, input mlsc_byte_t d,
        input mlsc_byte_t e);
        exp_q.push_back({1'b0, e});
        @(posedge sys_clk_i);
        cv <= 1'b1;
        cw <= w;
        ca <= a;
        cd <= d;
        do @(negedge sys_clk_i); while (rdy !== 1'b1);
        @(posedge sys_clk_i);
        cv <= 1'b0;
        while (exp_q.size() != 0) @(posedge sys_clk_i);
    endtask
    // Cycle ceiling
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    // Oldest note against each answer
    always @(negedge sys_clk_i) begin
        if (rv === 1'b1) begin
            check("answer", {re, ri, rd}, {1'b0, exp_q.size() ? exp_q.pop_front() : 9'h1FF});
        end
    end
    initial begin
        exp_q.push_back(9'h101);
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        settle("power-up");
        check("present", prs, 10'h001);
        check("ready", rdy_d, 10'h001);
        rs = xs(rs);
        cmd(1'b1, 8'h04, rs[7:0], 8'h00);
        cmd(1'b0, 8'h04, 8'h00, rs[7:0] & 8'h03);
        cmd(rs[16], {1'b1, rs[14:8]}, rs[31:24], 8'h00);
        cmd(1'b1, 8'h04, 8'h00, 8'h00);
        cmd(1'b1, 8'h05, 8'h01, 8'h00);
        check("cap", cap, 10'h001);
        cmd(1'b1, 8'h05, 8'h00, 8'h00);
        lp <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        check("cap", cap, 10'h001);
        lp <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        check("cap", cap, 10'h000);
        settle("map");
        exp_q.push_back(9'h102);
        flt <= 1'b1;
        @(posedge sys_clk_i);
        flt <= 1'b0;
        settle("fault");
        exp_q.push_back(9'h101);
        rq <= 1'b1;
        @(posedge sys_clk_i);
        rq <= 1'b0;
        repeat (40) begin
            @(negedge sys_clk_i);
            seen = seen | (inr === 1'b1);
        end
        check("hold", seen, 10'h001);
        settle("reset");
        check("status", sv, 10'h001);
        wrap_up();
    end
endmodule
